// ==== common/dauctl_pkg.sv ====
// constants, register layout and saturation helper for the arithmetic control block
// Behaviour
// - adder saturates only: three operands, no ALU
// - explicit X load overrides X-mirrors-Y mode
// - mirror mode: Y high load copies X high
// - mirror mode: Y high load, clear-ctrl zero, clears lows
// - mirror mode: Y low load copies X low
// - enabled store saturation clips stored value 32 bits
// - low, high, guard parts come from saturated value
// - accumulator contents never modified by store saturation
// - second control: 15 reserved, 14:12, 11:6, 5:0
// - saturation disable bit zero enables, one disables
// - high load clears low unless keep bit set; a0 and a1 never cleared
package dauctl_pkg;
  // register indices on the plain register port
  localparam logic [3:0] ADDR_CTRL_FIRST = 4'h0;
  localparam logic [3:0] ADDR_CTRL_SECOND = 4'h1;
  localparam logic [3:0] ADDR_STATUS = 4'h2;
  // first control register fields
  localparam int SHIFT_SEL_LSB = 0;
  localparam int SAT_DIS_A0 = 2;
  localparam int SAT_DIS_A1 = 3;
  localparam int RANDOM_GEN_DISABLE_DIS_BIT = 4;
  localparam int ADD_SAT_DIS_BIT = 5;
  localparam int Y_LOW_CLR_BIT = 6;
  localparam int X_MIRROR_BIT = 7;
  localparam logic [7:0] CTRL_FIRST_RESET = 8'h00;
  // second control register fields
  localparam int RESERVED_BIT = 15;
  localparam int FEEDBACK_LSB = 12;
  localparam int FEEDBACK_MSB = 14;
  localparam int LOW_KEEP_LSB = 6;
  localparam int LOW_KEEP_MSB = 11;
  localparam int SAT_DIS_LSB = 0;
  localparam int SAT_DIS_MSB = 5;
  localparam logic [14:0] CTRL_SECOND_RESET = 15'h0000;
  // product shift encodings
  localparam logic [1:0] SHIFT_NONE = 2'h0;
  localparam logic [1:0] SHIFT_R2 = 2'h1;
  localparam logic [1:0] SHIFT_L2 = 2'h2;
  localparam logic [1:0] SHIFT_L1 = 2'h3;
  // store part encodings
  localparam logic [1:0] PART_FULL = 2'h0;
  localparam logic [1:0] PART_LOW = 2'h1;
  localparam logic [1:0] PART_HIGH = 2'h2;
  localparam logic [1:0] PART_GUARD = 2'h3;
  // saturation limits, sign extended to 40 bits
  localparam logic [39:0] SAT_POS = 40'h00_7fff_ffff;
  localparam logic [39:0] SAT_NEG = 40'hff_8000_0000;
  // random generator seed, any nonzero value works
  localparam logic [15:0] LFSR_SEED = 16'h0001;

  // clip a 40-bit value to the signed 32-bit range
  function automatic logic [39:0] dauctl_sat32(input logic [39:0] v);
    if ((&v[39:31]) || !(|v[39:31]))
      return v;
    else if (v[39])
      return SAT_NEG;
    else
      return SAT_POS;
  endfunction : dauctl_sat32
endpackage : dauctl_pkg

// ==== core/dauctl_store_sat.sv ====
// store path: saturates accumulator values on their way to a destination
`timescale 1ns/1ps
module dauctl_store_sat
  import dauctl_pkg::*;
(
  // clock, reset, enable
  input wire logic core_clk,
  input wire logic rst,
  input wire logic ce,
  // store request
  input wire logic store_req,
  input wire logic [2:0] store_acc,
  input wire logic [1:0] store_part,
  input wire logic [39:0] store_value,
  input wire logic [7:0] sat_disable,
  // store result
  output logic [39:0] store_data,
  output logic store_valid
);
  logic [39:0] sat_value;

  // clip only when this accumulator has saturation enabled
  always_comb
  begin
    sat_value = sat_disable[store_acc] ? store_value : dauctl_sat32(store_value);
  end

  // the accumulator itself is never written here, only the copy
  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      store_data <= 40'h00_0000_0000;
      store_valid <= 1'b0;
    end
    else if (ce)
    begin
      store_valid <= store_req;
      if (store_req)
      begin
        unique case (store_part)
          PART_FULL: store_data <= sat_value;
          PART_LOW: store_data <= {24'h00_0000, sat_value[15:0]};
          PART_HIGH: store_data <= {24'h00_0000, sat_value[31:16]};
          PART_GUARD: store_data <= {32'h0000_0000, sat_value[39:32]};
        endcase
      end
    end
  end

  sequence s_store_ovf;
    ce && store_req && !sat_disable[store_acc] && store_part == PART_FULL
      && !((&store_value[39:31]) || !(|store_value[39:31]));
  endsequence

  chk_store_clip: assert property (@(posedge core_clk) disable iff (rst)
    s_store_ovf |=> store_valid && (store_data == SAT_POS || store_data == SAT_NEG))
    else $error("overflowing store not saturated");

  chk_store_raw: assert property (@(posedge core_clk) disable iff (rst)
    (ce && store_req && sat_disable[store_acc] && store_part == PART_FULL)
      |=> store_data == $past(store_value))
    else $error("disabled saturation altered store");
endmodule : dauctl_store_sat

// ==== core/dauctl_arith_ctrl.sv ====
// arithmetic unit control: registers, product shift, adder and store saturation, x/y loads
//
// The address map and the address-and-strobe port were left to the implementer.
`timescale 1ns/1ps
module dauctl_arith_ctrl
  import dauctl_pkg::*;
(
  // clock, reset, enable
  input wire logic core_clk,
  input wire logic rst,
  input wire logic ce,
  // register port
  input wire logic [3:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [15:0] reg_rdata,
  // product path
  input wire logic [31:0] product_in,
  output logic [31:0] product_shifted,
  // three-input adder
  input wire logic [39:0] adder_sum,
  input wire logic adder_three_operands,
  input wire logic alu_op_active,
  output logic [39:0] adder_result,
  // x and y operand loads
  input wire logic [31:0] x_data,
  input wire logic x_high_load,
  input wire logic x_low_load,
  input wire logic [31:0] y_data,
  input wire logic y_high_load,
  input wire logic y_low_load,
  output logic [31:0] x_reg,
  output logic [31:0] y_reg,
  // accumulator high-half loads
  input wire logic acc_high_load,
  input wire logic [2:0] acc_high_idx,
  output logic acc_low_clear,
  // accumulator stores
  input wire logic store_req,
  input wire logic [2:0] store_acc,
  input wire logic [1:0] store_part,
  input wire logic [39:0] store_value,
  output logic [39:0] store_data,
  output logic store_valid,
  // random generator
  output logic heads_tails,
  output logic [2:0] result_feedback_select
);
  logic [7:0] arith_control_first;
  logic [14:0] arith_control_second;
  logic [15:0] lfsr;
  logic [1:0] product_zero_shift_sel;
  logic random_gen_disable;
  logic y_low_clear_ctrl;
  logic x_mirror_mode;
  logic adder_sat_disable;
  logic [5:0] acc_low_keep;
  logic [7:0] sat_disable_all;
  logic [7:0] keep_all;
  logic x_any_load;
  logic adder_sat_apply;

  // field views of the control registers
  assign product_zero_shift_sel = arith_control_first[SHIFT_SEL_LSB +: 2];
  assign random_gen_disable = arith_control_first[RANDOM_GEN_DISABLE_DIS_BIT];
  assign adder_sat_disable = arith_control_first[ADD_SAT_DIS_BIT];
  assign y_low_clear_ctrl = arith_control_first[Y_LOW_CLR_BIT];
  assign x_mirror_mode = arith_control_first[X_MIRROR_BIT];
  assign acc_low_keep = arith_control_second[LOW_KEEP_MSB:LOW_KEEP_LSB];
  assign result_feedback_select = arith_control_second[FEEDBACK_MSB:FEEDBACK_LSB];
  assign sat_disable_all = {arith_control_second[SAT_DIS_MSB:SAT_DIS_LSB],
                            arith_control_first[SAT_DIS_A1], arith_control_first[SAT_DIS_A0]};
  // a0 and a1 have no keep bit, so they are never cleared here
  assign keep_all = {acc_low_keep, 2'b11};
  assign x_any_load = x_high_load | x_low_load;

  // register writes; the reserved top bit is not stored
  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      arith_control_first <= CTRL_FIRST_RESET;
      arith_control_second <= CTRL_SECOND_RESET;
    end
    else if (ce && reg_wr)
    begin
      if (reg_addr == ADDR_CTRL_FIRST)
        arith_control_first <= reg_wdata[7:0];
      if (reg_addr == ADDR_CTRL_SECOND)
        arith_control_second <= reg_wdata[14:0];
    end
  end

  // read data stands for one enabled cycle and holds while ce is low; zero on other enabled cycles and on unmapped reads
  always_ff @(posedge core_clk)
  begin
    if (rst)
      reg_rdata <= 16'h0000;
    else if (ce)
    begin
      reg_rdata <= 16'h0000;
      if (reg_rd)
      begin
        unique case (reg_addr)
          ADDR_CTRL_FIRST: reg_rdata <= {8'h00, arith_control_first};
          ADDR_CTRL_SECOND: reg_rdata <= {1'b0, arith_control_second};
          ADDR_STATUS: reg_rdata <= lfsr;
          default: reg_rdata <= 16'h0000;
        endcase
      end
    end
  end

  // pseudo-random generator; frozen while disabled
  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      lfsr <= LFSR_SEED;
      heads_tails <= 1'b0;
    end
    else if (ce && !random_gen_disable)
    begin
      lfsr <= {lfsr[14:0], lfsr[15] ^ lfsr[13] ^ lfsr[12] ^ lfsr[10]};
      heads_tails <= lfsr[15]; // lags one cycle, hence the wait after re-enable
    end
  end

  // product register shift, arithmetic on the right shift
  always_ff @(posedge core_clk)
  begin
    if (rst)
      product_shifted <= 32'h0000_0000;
    else if (ce)
    begin
      unique case (product_zero_shift_sel)
        SHIFT_NONE: product_shifted <= product_in;
        SHIFT_R2: product_shifted <= {{2{product_in[31]}}, product_in[31:2]};
        SHIFT_L2: product_shifted <= {product_in[29:0], 2'b00};
        SHIFT_L1: product_shifted <= {product_in[30:0], 1'b0};
      endcase
    end
  end

  // adder saturation is gated so ALU and ACS cycles see raw sums
  assign adder_sat_apply = adder_three_operands && !alu_op_active && !adder_sat_disable;
  always_ff @(posedge core_clk)
  begin
    if (rst)
      adder_result <= 40'h00_0000_0000;
    else if (ce)
      adder_result <= adder_sat_apply ? dauctl_sat32(adder_sum) : adder_sum;
  end

  // y register: explicit loads, then the clear of the low half on a high load in mirror mode
  always_ff @(posedge core_clk)
  begin
    if (rst)
      y_reg <= 32'h0000_0000;
    else if (ce)
    begin
      if (y_high_load)
        y_reg[31:16] <= y_data[31:16];
      if (y_low_load)
        y_reg[15:0] <= y_data[15:0];
      else if (x_mirror_mode && y_high_load && !y_low_clear_ctrl)
        y_reg[15:0] <= 16'h0000;
    end
  end

  // x register: any explicit x load shuts out mirroring for the cycle
  always_ff @(posedge core_clk)
  begin
    if (rst)
      x_reg <= 32'h0000_0000;
    else if (ce)
    begin
      if (x_any_load)
      begin
        if (x_high_load)
          x_reg[31:16] <= x_data[31:16];
        if (x_low_load)
          x_reg[15:0] <= x_data[15:0];
      end
      else if (x_mirror_mode)
      begin
        if (y_high_load)
          x_reg[31:16] <= y_data[31:16];
        if (y_low_load)
          x_reg[15:0] <= y_data[15:0];
        else if (y_high_load && !y_low_clear_ctrl)
          x_reg[15:0] <= 16'h0000;
      end
    end
  end

  // low-half clear strobe toward the accumulator file
  always_ff @(posedge core_clk)
  begin
    if (rst)
      acc_low_clear <= 1'b0;
    else if (ce)
      acc_low_clear <= acc_high_load && !keep_all[acc_high_idx];
  end

  dauctl_store_sat u_store_sat (
    .core_clk(core_clk),
    .rst(rst),
    .ce(ce),
    .store_req(store_req),
    .store_acc(store_acc),
    .store_part(store_part),
    .store_value(store_value),
    .sat_disable(sat_disable_all),
    .store_data(store_data),
    .store_valid(store_valid)
  );

  sequence s_mirror_yh;
    ce && x_mirror_mode && y_high_load && !x_any_load;
  endsequence

  sequence s_mirror_clr;
    ce && x_mirror_mode && y_high_load && !y_low_load && !x_any_load && !y_low_clear_ctrl;
  endsequence

  sequence s_mirror_yl;
    ce && x_mirror_mode && y_low_load && !y_high_load && !x_any_load;
  endsequence

  chk_shift_left_two: assert property (@(posedge core_clk) disable iff (rst)
    (ce && product_zero_shift_sel == SHIFT_L2) |=> product_shifted == {$past(product_in[29:0]), 2'b00})
    else $error("product not shifted left by two");

  chk_shift_left_one: assert property (@(posedge core_clk) disable iff (rst)
    (ce && product_zero_shift_sel == SHIFT_L1) |=> product_shifted == {$past(product_in[30:0]), 1'b0})
    else $error("product not shifted left by one");

  chk_adder_sat_gate: assert property (@(posedge core_clk) disable iff (rst)
    (ce && (!adder_three_operands || alu_op_active)) |=> adder_result == $past(adder_sum))
    else $error("adder saturated outside three-operand case");

  chk_x_load_wins: assert property (@(posedge core_clk) disable iff (rst)
    (ce && x_high_load && x_mirror_mode) |=> x_reg[31:16] == $past(x_data[31:16]))
    else $error("mirror overrode explicit x load");

  chk_mirror_high_copy: assert property (@(posedge core_clk) disable iff (rst)
    s_mirror_yh |=> x_reg[31:16] == $past(y_data[31:16]))
    else $error("x high did not follow y high");

  chk_mirror_low_clear: assert property (@(posedge core_clk) disable iff (rst)
    s_mirror_clr |=> x_reg[15:0] == 16'h0000
      && y_reg[15:0] == 16'h0000)
    else $error("low halves not cleared on y high load");

  chk_mirror_low_copy: assert property (@(posedge core_clk) disable iff (rst)
    s_mirror_yl |=> x_reg[15:0] == $past(y_data[15:0]) && x_reg[31:16] == $past(x_reg[31:16]))
    else $error("x low mirror wrong");

  chk_reserved_zero: assert property (@(posedge core_clk) disable iff (rst)
    (ce && reg_rd && reg_addr == ADDR_CTRL_SECOND) |=> reg_rdata[RESERVED_BIT] == 1'b0)
    else $error("reserved bit read nonzero");

  chk_low_keep_clear: assert property (@(posedge core_clk) disable iff (rst)
    (ce && acc_high_load && acc_high_idx >= 3'd2 && !acc_low_keep[acc_high_idx - 3'd2])
      |=> acc_low_clear)
    else $error("low half clear missing");
endmodule : dauctl_arith_ctrl

// ==== testbench/arith_unit_store_saturation_ctrl_test.sv ====
// self-checking bench for the arithmetic control block
`timescale 1ns/1ps
`define CMP(a, e) begin check_count++; if ((a) !== (e)) begin n_mismatch++; \
  $display("ERROR t=%0t got %h exp %h", $time, a, e); end end
module arith_unit_store_saturation_ctrl_test;
  import dauctl_pkg::*;
  // design inputs and outputs
  logic core_clk, rst, ce, reg_wr, reg_rd, x_high_load, x_low_load, y_high_load, y_low_load;
  logic acc_high_load, store_req, adder_three_operands, alu_op_active;
  logic acc_low_clear, store_valid, heads_tails;
  logic [3:0] reg_addr;
  logic [15:0] reg_wdata, reg_rdata;
  logic [31:0] product_in, product_shifted, x_data, y_data, x_reg, y_reg;
  logic [39:0] adder_sum, adder_result, store_value, store_data;
  logic [2:0] acc_high_idx, store_acc, result_feedback_select;
  logic [1:0] store_part;
  // bench state: counters, generator, x/y model, expectation queue
  int n_mismatch = 0;
  int check_count = 0;
  int cyc_n = 0;
  logic [31:0] rng = 32'h781c_5053;
  logic [31:0] xm = 32'h0000_0000;
  logic [31:0] ym = 32'h0000_0000;
  logic mir = 1'b0;
  logic ykeep = 1'b0;
  typedef struct {int due; int sel; logic [39:0] val;} dauctl_note_s;
  dauctl_note_s q[$];

  dauctl_arith_ctrl u_dut (.core_clk(core_clk), .rst(rst), .ce(ce), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .product_in(product_in), .product_shifted(product_shifted), .adder_sum(adder_sum),
    .adder_three_operands(adder_three_operands), .alu_op_active(alu_op_active),
    .adder_result(adder_result), .x_data(x_data), .x_high_load(x_high_load),
    .x_low_load(x_low_load), .y_data(y_data), .y_high_load(y_high_load),
    .y_low_load(y_low_load), .x_reg(x_reg), .y_reg(y_reg), .acc_high_load(acc_high_load),
    .acc_high_idx(acc_high_idx), .acc_low_clear(acc_low_clear), .store_req(store_req),
    .store_acc(store_acc), .store_part(store_part), .store_value(store_value),
    .store_data(store_data), .store_valid(store_valid), .heads_tails(heads_tails),
    .result_feedback_select(result_feedback_select));

  // 200 MHz clock
  initial
  begin
    core_clk = 1'b0;
    forever #2.5 core_clk = ~core_clk;
  end

  // cycle stamp; notes fall due one edge after the driving edge
  always @(posedge core_clk) cyc_n <= cyc_n + 1;

  function automatic logic [31:0] rnd();
    rng = rng ^ (rng << 13);
    rng = rng ^ (rng >> 17);
    rng = rng ^ (rng << 5);
    return rng;
  endfunction : rnd

  // own clip to signed 32, kept apart from the design's helper
  function automatic logic [39:0] sat(input logic [39:0] v);
    if (v[39:31] == 9'h000 || v[39:31] == 9'h1ff)
      return v;
    return v[39] ? 40'hff_8000_0000 : 40'h00_7fff_ffff;
  endfunction : sat

  task automatic note(input int sel, input logic [39:0] val);
    q.push_back('{cyc_n + 2, sel, val});
  endtask : note

  // every strobe is set once per edge, so back-to-back ops never double-drive
  task automatic cyc(input logic [7:0] s);
    @(posedge core_clk);
    {store_req, acc_high_load, y_low_load, y_high_load, x_low_load, x_high_load, reg_rd,
      reg_wr} <= s;
  endtask : cyc

  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    cyc(8'h01);
    reg_addr <= a;
    reg_wdata <= d;
  endtask : wr

  task automatic rd(input logic [3:0] a, input logic [15:0] e);
    cyc(8'h02);
    reg_addr <= a;
    note(0, {24'h00_0000, e});
  endtask : rd

  // x/y load with the bench's own copy of both registers
  task automatic xy(input logic [7:0] s);
    logic [31:0] xd;
    logic [31:0] yd;
    xd = rnd();
    yd = rnd();
    cyc(s);
    x_data <= xd;
    y_data <= yd;
    if (s[2]) xm[31:16] = xd[31:16];
    if (s[3]) xm[15:0] = xd[15:0];
    if (s[4]) ym[31:16] = yd[31:16];
    if (s[5]) ym[15:0] = yd[15:0];
    if (mir && !s[2] && !s[3])
    begin
      if (s[4]) xm[31:16] = yd[31:16];
      if (s[5]) xm[15:0] = yd[15:0];
      else if (s[4] && !ykeep) xm[15:0] = 16'h0000;
    end
    // y low clears on a y high load even when x is loaded explicitly
    if (mir && s[4] && !s[5] && !ykeep) ym[15:0] = 16'h0000;
    note(3, {8'h00, xm});
    note(4, {8'h00, ym});
  endtask : xy

  task automatic close_out();
    $display("checks %0d mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : close_out

  // monitor: pops each note when its result is due and compares
  always @(negedge core_clk)
  begin
    dauctl_note_s nt;
    logic [39:0] act;
    while (q.size() != 0 && q[0].due <= cyc_n)
    begin
      nt = q.pop_front();
      case (nt.sel)
        0: act = {24'h00_0000, reg_rdata};
        1: act = {8'h00, product_shifted};
        2: act = adder_result;
        3: act = {8'h00, x_reg};
        4: act = {8'h00, y_reg};
        5: act = store_data;
        6: act = {39'h00_0000_0000, store_valid};
        7: act = {39'h00_0000_0000, acc_low_clear};
        9: act = {39'h00_0000_0000, heads_tails};
        default: act = {37'h00_0000_0000, result_feedback_select};
      endcase
      `CMP(act, nt.val)
    end
  end

  // hang guard
  initial
  begin
    repeat (20000) @(posedge core_clk);
    n_mismatch++;
    close_out();
  end

  // main sequence
  initial
  begin
    logic [31:0] p;
    logic signed [31:0] ps;
    logic [31:0] pe [4];
    logic [39:0] v;
    logic [39:0] sv;
    logic [7:0] dis;
    {store_req, acc_high_load, y_low_load, y_high_load, x_low_load, x_high_load} = 6'h00;
    {reg_rd, reg_wr, adder_three_operands, alu_op_active} = 4'h0;
    {reg_addr, reg_wdata, product_in, adder_sum, x_data, y_data} = 0;
    {acc_high_idx, store_acc, store_part, store_value} = 0;
    ce = 1'b1;
    rst = 1'b1;
    repeat (3) @(posedge core_clk);
    rst <= 1'b0;
    rd(ADDR_CTRL_FIRST, 16'h0000);
    rd(ADDR_CTRL_SECOND, 16'h0000);
    rd(4'hf, 16'h0000);
    wr(ADDR_CTRL_SECOND, 16'hffff);
    rd(ADDR_CTRL_SECOND, 16'h7fff);
    note(8, 40'h00_0000_0007);
    // freeze the generator while the seed is still a lone bit moving up
    wr(ADDR_CTRL_FIRST, 16'h0010);
    rd(ADDR_STATUS, 16'h0080);
    note(9, 40'h00_0000_0000);
    for (int s = 0; s < 4; s++)
    begin
      wr(ADDR_CTRL_FIRST, 16'(s));
      p = rnd();
      ps = $signed(p) >>> 2;
      pe = '{p, ps, p << 2, p << 1};
      cyc(8'h00);
      product_in <= p;
      note(1, {8'h00, pe[s]});
    end
    wr(ADDR_CTRL_FIRST, 16'h0000);
    for (int k = 0; k < 5; k++)
    begin
      if (k == 4) wr(ADDR_CTRL_FIRST, 16'h0020);
      v = k[0] ? {8'h85, rnd()} : {8'h12, rnd()};
      cyc(8'h00);
      adder_sum <= v;
      adder_three_operands <= k[0] || k == 4;
      alu_op_active <= k[1];
      note(2, k == 1 ? sat(v) : v);
    end
    // mirror mode with low clear, then with low keep, then off
    wr(ADDR_CTRL_FIRST, 16'h0080);
    mir = 1'b1;
    xy(8'h20);
    xy(8'h10);
    xy(8'h20);
    xy(8'h14);
    xy(8'h28);
    wr(ADDR_CTRL_FIRST, 16'h00c0);
    ykeep = 1'b1;
    xy(8'h10);
    wr(ADDR_CTRL_FIRST, 16'h0000);
    mir = 1'b0;
    xy(8'h30);
    // keep a3, a5, a7 lows; saturation off for a1, a2, a4, a6
    wr(ADDR_CTRL_SECOND, 16'h0a95);
    for (int i = 0; i < 8; i++)
    begin
      cyc(8'h40);
      acc_high_idx <= i[2:0];
      note(7, {39'h00_0000_0000, (i > 1) && (((6'b10_1010 >> (i - 2)) & 6'h01) == 6'h00)});
    end
    wr(ADDR_CTRL_FIRST, 16'h0008);
    dis = 8'b0101_0110;
    for (int i = 0; i < 32; i++)
    begin
      p = rnd();
      v = p[31] ? {8'h9c, p} : {8'h3a, p};
      sv = dis[i[4:2]] ? v : sat(v);
      cyc(8'h80);
      store_acc <= i[4:2];
      store_part <= i[1:0];
      store_value <= v;
      pe = '{sv[31:0], {16'h0000, sv[15:0]}, {16'h0000, sv[31:16]}, {24'h00_0000, sv[39:32]}};
      note(5, i[1:0] == 2'h0 ? sv : {8'h00, pe[i[1:0]]});
      note(6, 40'h00_0000_0001);
    end
    cyc(8'h00);
    note(6, 40'h00_0000_0000);
    // freeze then re-enable the generator, one idle cycle before any heads test
    wr(ADDR_CTRL_FIRST, 16'h0010);
    wr(ADDR_CTRL_FIRST, 16'h0000);
    cyc(8'h00);
    // a write while the enable is low must be lost
    wr(ADDR_CTRL_FIRST, 16'h0003);
    ce <= 1'b0;
    cyc(8'h00);
    ce <= 1'b1;
    rd(ADDR_CTRL_FIRST, 16'h0000);
    repeat (4) cyc(8'h00);
    if (q.size() != 0) n_mismatch++;
    close_out();
  end
endmodule : arith_unit_store_saturation_ctrl_test
